// >>> common/arc_consts.svh
// Constants for the alternate-space register error checker
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH

// Data width of every protected register
`define ARC_DW 8
// Width of the SECDED code word: 8 data, 4 check, 1 overall parity
`define ARC_CW 13
`define ARC_NPAR 6

// Parity-protected word indices, which are also register-port indices
`define ARC_W_CTL 0
`define ARC_W_TICK 1
`define ARC_W_AFAR 2
`define ARC_W_FAC 3
`define ARC_W_IBASE 4
`define ARC_W_DBASE 5
`define ARC_IDX_ECC 3'h6

// Translation-table pointer indices
`define ARC_NPTR 5
`define ARC_P_I8K 0
`define ARC_P_I64K 1
`define ARC_P_D8K 2
`define ARC_P_D64K 3
`define ARC_P_DDIR 4

// Urgent error status bit positions
`define ARC_UG_ITP 0
`define ARC_UG_DTP 1
`define ARC_UG_AUG_CRE 2
`define ARC_UG_IAUG_CRE 3
`define ARC_UG_TSBCTXT 4
`define ARC_UG_TLB 5
`define ARC_UG_BV 6
`define ARC_UG_RX 7
`define ARC_UG_W 8
`define ARC_UG_INSTR_MASK 8'h1b
`define ARC_UG_AUTO_MASK 8'he4

// Reset values
`define ARC_RST_WORD 9'h000
`define ARC_RST_ECC 13'h0000
`define ARC_RST_UG 8'h00
`define ARC_RST_DATA 8'h00

`endif

// >>> common/arc_pkg.sv
// Types for the alternate-space register error checker
`default_nettype none
package arc_pkg;

    typedef enum logic [1:0] {
        ARC_RX_IDLE = 2'b00,
        ARC_RX_BUSY = 2'b01,
        ARC_RX_HOLD = 2'b10
    } arc_rx_t;

endpackage
`default_nettype wire

// >>> rtl/arc_check.sv
// Error protection, detect conditions and urgent-error classification for ASI registers
`timescale 1ns/10ps
`default_nettype none
`include "arc_consts.svh"

// How it works
// R1: The ECC register stores a SECDED code: fixes single, flags double bit errors.
// R2: Pointer registers inherit the parity error of the source register they came from.
// R3: Always-checked registers are checked every cycle regardless of access or mode.
// R4: Autonomous-period checks run only while handler-active and weak-detect are both 0.
// R5: Read-checked registers are checked when an alternate-space load reads them.
// R6: An instruction base error propagates into both instruction table pointers.
// R7: Reading an instruction pointer carrying that error raises the instruction pointer error.
// R8: A data base error propagates into the three data table pointers.
// R9: Reading a data pointer carrying that error raises the data pointer error.
// R10: The instruction base is checked at the instruction TLB update point.
// R11: The data base is checked at the data TLB update point.
// R12: The base registers are checked whenever they take part in a TLB lookup.
// R13: The facility register is checked only while its facility is enabled.
// R14: An errored interrupt packet still traps but leaves the busy flag at 0.
// R15: After an errored packet no new packet is taken until busy is written 0.
// R16: Barrier-variable transfer errors are checked throughout the autonomous period.
// R17: Autonomous-class errors set their flag in the urgent error status register.
// R18: Instruction-class errors set their flag and pulse the instruction-bound error output.
// R19: Each error type is identified by the named status bit it sets.
// R20: Parity words keep one parity bit, flag a mismatch, and never correct.

module arc_check
    import arc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic urgent_handler_active,
    input wire logic weak_error_detect,
    input wire logic facility_enable,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [`ARC_DW-1:0] wr_data,
    input wire logic [`ARC_CW-1:0] wr_flip,
    input wire logic rd_en,
    input wire logic [2:0] rd_idx,
    output logic [`ARC_DW-1:0] rd_data,
    output logic rd_valid,
    input wire logic ptr_update,
    input wire logic ptr_rd,
    input wire logic [2:0] ptr_sel,
    output logic [`ARC_DW-1:0] ptr_data,
    output logic ptr_valid,
    input wire logic itlb_update,
    input wire logic dtlb_update,
    input wire logic tlb_use_i,
    input wire logic tlb_use_d,
    input wire logic pkt_valid,
    input wire logic pkt_ue,
    input wire logic [`ARC_DW-1:0] pkt_data,
    input wire logic intr_busy_wr,
    input wire logic intr_busy_wdata,
    output logic intr_busy,
    output logic [`ARC_DW-1:0] intr_data,
    output logic vector_trap,
    input wire logic bv_valid,
    input wire logic bv_ue,
    input wire logic [`ARC_UG_W-1:0] ugesr_clr,
    output logic [`ARC_UG_W-1:0] urgent_error_status_reg,
    output logic error_state,
    output logic instr_urgent,
    output logic auto_urgent,
    output logic ecc_corrected
);

    ////////////////////////////////////////////////////////////////////////////////
    // SECDED code: Hamming positions 1..12, overall parity in bit 0

    // Data fills the non-power-of-two positions; check bits sit at 1, 2, 4 and 8
    function automatic logic [`ARC_CW-1:0] ecc_enc(input logic [`ARC_DW-1:0] d);
        logic [`ARC_CW-1:0] c;
        int k;
        c = `ARC_RST_ECC;
        k = 0;
        for (int i = 1; i < `ARC_CW; i++) begin
            if ((i & (i - 1)) != 0) begin
                c[i] = d[k];
                k++;
            end
        end
        for (int j = 0; j < 4; j++) begin
            for (int i = 1; i < `ARC_CW; i++) begin
                if (i != (1 << j) && ((i >> j) & 1) == 1) begin
                    c[1 << j] = c[1 << j] ^ c[i];
                end
            end
        end
        c[0] = ^c[`ARC_CW-1:1];
        return c;
    endfunction

    // Returns {uncorrectable, corrected, data}
    function automatic logic [`ARC_DW+1:0] ecc_dec(input logic [`ARC_CW-1:0] c);
        logic [`ARC_CW-1:0] f;
        logic [3:0] s;
        logic [`ARC_DW-1:0] d;
        logic odd;
        int k;
        f = c;
        s = 4'h0;
        d = `ARC_RST_DATA;
        odd = ^c;
        k = 0;
        for (int i = 1; i < `ARC_CW; i++) begin
            if (c[i]) begin
                s = s ^ 4'(i);
            end
        end
        // A syndrome beyond the last position can only come from a multi-bit error
        if (odd && s != 4'h0 && s < 4'hd) begin
            f[s] = ~f[s];
        end
        for (int i = 1; i < `ARC_CW; i++) begin
            if ((i & (i - 1)) != 0) begin
                d[k] = f[i];
                k++;
            end
        end
        return {(!odd && s != 4'h0) || (odd && s > 4'hc), odd && s < 4'hd, d};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [`ARC_NPAR-1:0][`ARC_DW:0] word_q;
    logic [`ARC_NPAR-1:0][`ARC_DW:0] word_d;
    logic [`ARC_NPAR-1:0] par_err;
    logic [`ARC_NPAR-1:0] par_rd;
    logic [`ARC_CW-1:0] ecc_q;
    logic [`ARC_NPTR-1:0][`ARC_DW-1:0] ptr_q;
    logic [`ARC_NPTR-1:0][`ARC_DW-1:0] ptr_d;
    logic [`ARC_NPTR-1:0] ptr_ue_q;
    logic [`ARC_NPTR-1:0] ptr_ue_d;

    for (genvar g = 0; g < `ARC_NPAR; g++) begin : g_par
        // One parity bit per word; a mismatch is reported, never repaired [R20]
        assign par_err[g] = ^word_q[g];
        assign par_rd[g] = rd_en && rd_idx == 3'(g);
        assign word_d[g] = (wr_en && wr_idx == 3'(g)) ?
            {^wr_data ^ wr_flip[0], wr_data} : word_q[g];
    end

    wire ecc_we = wr_en && wr_idx == `ARC_IDX_ECC;
    wire [`ARC_CW-1:0] ecc_d = ecc_we ? (ecc_enc(wr_data) ^ wr_flip) : ecc_q; // [R1]
    // Decoder sits on the stored word, so a read sees the corrected value at once
    wire [`ARC_DW+1:0] ecc_out = ecc_dec(ecc_q); // [R1]
    wire ecc_rd = rd_en && rd_idx == `ARC_IDX_ECC;

    ////////////////////////////////////////////////////////////////////////////////
    // Translation-table pointers and propagated errors

    wire [`ARC_DW-1:0] ibase = word_q[`ARC_W_IBASE][`ARC_DW-1:0];
    wire [`ARC_DW-1:0] dbase = word_q[`ARC_W_DBASE][`ARC_DW-1:0];
    wire ibase_err = par_err[`ARC_W_IBASE];
    wire dbase_err = par_err[`ARC_W_DBASE];

    assign ptr_d[`ARC_P_I8K] = ptr_update ? ibase : ptr_q[`ARC_P_I8K];
    assign ptr_d[`ARC_P_I64K] = ptr_update ? {ibase[6:0], 1'b0} : ptr_q[`ARC_P_I64K];
    assign ptr_d[`ARC_P_D8K] = ptr_update ? dbase : ptr_q[`ARC_P_D8K];
    assign ptr_d[`ARC_P_D64K] = ptr_update ? {dbase[6:0], 1'b0} : ptr_q[`ARC_P_D64K];
    assign ptr_d[`ARC_P_DDIR] = ptr_update ? {dbase[7:1], 1'b1} : ptr_q[`ARC_P_DDIR];
    // The source error travels with the computed pointer until the next update [R2]
    assign ptr_ue_d[`ARC_P_I8K] = ptr_update ? ibase_err : ptr_ue_q[`ARC_P_I8K]; // [R6]
    assign ptr_ue_d[`ARC_P_I64K] = ptr_update ? ibase_err : ptr_ue_q[`ARC_P_I64K]; // [R6]
    assign ptr_ue_d[`ARC_P_D8K] = ptr_update ? dbase_err : ptr_ue_q[`ARC_P_D8K]; // [R8]
    assign ptr_ue_d[`ARC_P_D64K] = ptr_update ? dbase_err : ptr_ue_q[`ARC_P_D64K]; // [R8]
    assign ptr_ue_d[`ARC_P_DDIR] = ptr_update ? dbase_err : ptr_ue_q[`ARC_P_DDIR]; // [R8]

    // Selects past the last pointer read as zero and never raise an error
    wire ptr_ok = ptr_sel < 3'(`ARC_NPTR);
    wire ptr_is_i = ptr_sel < 3'(`ARC_P_D8K);
    wire ptr_sel_ue = ptr_ok && ptr_ue_q[ptr_sel];
    wire [`ARC_DW-1:0] ptr_sel_data = ptr_ok ? ptr_q[ptr_sel] : `ARC_RST_DATA;

    ////////////////////////////////////////////////////////////////////////////////
    // Detect conditions and classification

    // The autonomous period gates the tick word and the barrier-variable interface
    wire aug_period = !urgent_handler_active && !weak_error_detect; // [R4]
    logic [`ARC_UG_W-1:0] ug_set;

    assign ug_set[`ARC_UG_ITP] = ptr_rd && ptr_is_i && ptr_sel_ue; // [R7]
    assign ug_set[`ARC_UG_DTP] = ptr_rd && !ptr_is_i && ptr_sel_ue; // [R9]
    assign ug_set[`ARC_UG_AUG_CRE] = (aug_period && par_err[`ARC_W_TICK]) // [R4]
        || (facility_enable && par_err[`ARC_W_FAC]); // [R13]
    assign ug_set[`ARC_UG_IAUG_CRE] = (par_rd[`ARC_W_AFAR] && par_err[`ARC_W_AFAR]) // [R5]
        || (ecc_rd && ecc_out[`ARC_DW+1]); // [R1]
    assign ug_set[`ARC_UG_TSBCTXT] = (par_rd[`ARC_W_IBASE] && ibase_err) // [R5]
        || (par_rd[`ARC_W_DBASE] && dbase_err);
    // Update and lookup events share one flag; the cause is known from context
    assign ug_set[`ARC_UG_TLB] = (itlb_update && ibase_err) // [R10]
        || (dtlb_update && dbase_err) // [R11]
        || ((tlb_use_i && ibase_err) || (tlb_use_d && dbase_err)); // [R12]
    assign ug_set[`ARC_UG_BV] = bv_valid && bv_ue && aug_period; // [R16]

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt receive

    arc_rx_t rx_q;
    arc_rx_t rx_d;

    // Packets arriving while busy or held are dropped, not queued
    always_comb begin
        rx_d = rx_q;
        case (rx_q)
            ARC_RX_IDLE: begin
                if (pkt_valid) begin
                    rx_d = pkt_ue ? ARC_RX_HOLD : ARC_RX_BUSY; // [R14]
                end
            end
            ARC_RX_BUSY, ARC_RX_HOLD: begin
                if (intr_busy_wr && !intr_busy_wdata) begin
                    rx_d = ARC_RX_IDLE; // [R15]
                end
            end
            default: begin
                rx_d = ARC_RX_IDLE;
            end
        endcase
    end

    // Held keeps busy low yet refuses packets until busy is written 0
    wire rx_take = rx_q == ARC_RX_IDLE && pkt_valid;
    assign ug_set[`ARC_UG_RX] = rx_take && pkt_ue; // [R19]
    wire [`ARC_DW-1:0] rx_data_d = (rx_take && !pkt_ue) ? pkt_data : intr_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and status

    // Index 7 reads as zero
    wire [`ARC_DW-1:0] rd_mux = (rd_idx < 3'(`ARC_NPAR)) ? word_q[rd_idx][`ARC_DW-1:0] :
        (ecc_rd ? ecc_out[`ARC_DW-1:0] : `ARC_RST_DATA);
    // A new error beats a clear in the same cycle
    wire [`ARC_UG_W-1:0] ug_d = (urgent_error_status_reg & ~ugesr_clr) | ug_set; // [R17]
    wire instr_d = |(ug_set & `ARC_UG_INSTR_MASK); // [R18]
    wire auto_d = |(ug_set & `ARC_UG_AUTO_MASK); // [R17]

    // Stored state; clk_en low freezes everything, outputs included
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            word_q <= {`ARC_NPAR{`ARC_RST_WORD}};
            ecc_q <= `ARC_RST_ECC;
            ptr_q <= {`ARC_NPTR{`ARC_RST_DATA}};
            ptr_ue_q <= '0;
            rx_q <= ARC_RX_IDLE;
        end else if (clk_en) begin
            word_q <= word_d;
            ecc_q <= ecc_d;
            ptr_q <= ptr_d;
            ptr_ue_q <= ptr_ue_d;
            rx_q <= rx_d;
        end
    end

    // Read answers are registered one cycle after the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_data <= `ARC_RST_DATA;
            rd_valid <= 1'b0;
            ptr_data <= `ARC_RST_DATA;
            ptr_valid <= 1'b0;
            ecc_corrected <= 1'b0;
        end else if (clk_en) begin
            rd_data <= rd_en ? rd_mux : rd_data;
            rd_valid <= rd_en;
            ptr_data <= ptr_rd ? ptr_sel_data : ptr_data;
            ptr_valid <= ptr_rd;
            ecc_corrected <= ecc_rd && ecc_out[`ARC_DW]; // [R1]
        end
    end

    // Status and class outputs; error_state has no clear short of reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            urgent_error_status_reg <= `ARC_RST_UG;
            error_state <= 1'b0;
            instr_urgent <= 1'b0;
            auto_urgent <= 1'b0;
            intr_data <= `ARC_RST_DATA;
            vector_trap <= 1'b0;
        end else if (clk_en) begin
            urgent_error_status_reg <= ug_d; // [R19]
            error_state <= error_state || par_err[`ARC_W_CTL]; // [R3]
            instr_urgent <= instr_d;
            auto_urgent <= auto_d;
            intr_data <= rx_data_d;
            vector_trap <= rx_take; // [R14]
        end
    end

    // Busy is bit 0 of the receive state, so a held state reads as not busy
    assign intr_busy = rx_q[0]; // [R14]

endmodule

`default_nettype wire

// >>> test/arc_check_bench.sv
// Self-checking bench for the register error checker
`timescale 1ns/10ps
`default_nettype none
module arc_check_bench import arc_pkg::*;;
    typedef struct packed {
        logic [2:0] idx;
        logic [7:0] d;
        logic [12:0] f;
        logic [7:0] st;
        logic ce;
        logic dc;
    } arc_row_t;
    logic clock = 1'h0, resetn = 1'h0, clk_en = 1'h1, facility_enable = 1'h0;
    logic urgent_handler_active = 1'h0, weak_error_detect = 1'h0, wr_en = 1'h0;
    logic [2:0] wr_idx = 3'h0, ptr_sel = 3'h0, go_idx = 3'h0, rd_idx;
    logic [7:0] wr_data = 8'h00, pkt_data = 8'h00, ugesr_clr = 8'h00;
    logic [12:0] wr_flip = 13'h0000;
    logic ptr_update = 1'h0, ptr_rd = 1'h0, itlb_update = 1'h0, dtlb_update = 1'h0;
    logic tlb_use_i = 1'h0, tlb_use_d = 1'h0, pkt_valid = 1'h0, pkt_ue = 1'h0;
    logic intr_busy_wr = 1'h0, intr_busy_wdata = 1'h0, bv_valid = 1'h0, bv_ue = 1'h0;
    logic go = 1'h0, slow = 1'h0, rd_en, rd_valid, ptr_valid, intr_busy, vector_trap;
    logic error_state, instr_urgent, auto_urgent, ecc_corrected;
    logic [7:0] rd_data, ptr_data, intr_data, urgent_error_status_reg;
    int num_errors = 0, check_count = 0;
    // Double flip on the ECC word cannot be corrected, so its data is not compared
    arc_row_t rows [8] = '{'{3'h2, 8'ha5, 13'h0001, 8'h08, 1'h0, 1'h1},
        '{3'h2, 8'h3c, 13'h0000, 8'h00, 1'h0, 1'h1}, '{3'h6, 8'h5a, 13'h0000, 8'h00, 1'h0, 1'h1},
        '{3'h6, 8'h5a, 13'h0010, 8'h00, 1'h1, 1'h1}, '{3'h6, 8'hc3, 13'h0100, 8'h00, 1'h1, 1'h1},
        '{3'h6, 8'h5a, 13'h0006, 8'h08, 1'h0, 1'h0}, '{3'h7, 8'hff, 13'h0000, 8'h00, 1'h0, 1'h1},
        '{3'h4, 8'h11, 13'h0001, 8'h10, 1'h0, 1'h1}};
    arc_check dut (.clock, .resetn, .clk_en, .urgent_handler_active, .weak_error_detect,
        .facility_enable, .wr_en, .wr_idx, .wr_data, .wr_flip, .rd_en, .rd_idx, .rd_data,
        .rd_valid, .ptr_update, .ptr_rd, .ptr_sel, .ptr_data, .ptr_valid, .itlb_update,
        .dtlb_update, .tlb_use_i, .tlb_use_d, .pkt_valid, .pkt_ue, .pkt_data, .intr_busy_wr,
        .intr_busy_wdata, .intr_busy, .intr_data, .vector_trap, .bv_valid, .bv_ue, .ugesr_clr,
        .urgent_error_status_reg, .error_state, .instr_urgent, .auto_urgent, .ecc_corrected);
    arc_pipe_model pipe (.clock, .go, .go_idx, .slow, .rd_en, .rd_idx);
    always #4 clock = ~clock;
    ////////////////////////////////////////
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        tick;
        s = 1'h0;
    endtask
    task automatic clr;
        ugesr_clr = 8'hff;
        tick;
        ugesr_clr = 8'h00;
    endtask
    task automatic wr(input logic [2:0] i, input logic [7:0] d, input logic [12:0] f);
        wr_idx = i;
        wr_data = d;
        wr_flip = f;
        pulse(wr_en);
        // Idle cycle so back-to-back writes never re-raise the strobe in one step
        tick;
    endtask
    task automatic rd(input logic [2:0] i);
        go_idx = i;
        pulse(go);
        for (int n = 0; n < 8 && rd_valid !== 1'h1; n++) tick;
        chk(rd_valid, 1'h1);
    endtask
    task automatic pr(input logic [2:0] s, input logic [7:0] d, input logic [7:0] st);
        ptr_sel = s;
        pulse(ptr_rd);
        chk(ptr_valid, 1'h1);
        chk(ptr_data, d);
        chk(urgent_error_status_reg, st);
        clr();
    endtask
    ////////////////////////////////////////
    initial begin
        #20000;
        num_errors++;
        results();
    end
    initial begin
        repeat (4) @(posedge clock);
        #1;
        resetn = 1'h1;
        foreach (rows[k]) begin
            slow = k[0];
            clr();
            wr(rows[k].idx, rows[k].d, rows[k].f);
            rd(rows[k].idx);
            chk(urgent_error_status_reg, rows[k].st);
            chk(ecc_corrected, rows[k].ce);
            chk(instr_urgent, |rows[k].st);
            if (rows[k].dc) begin
                chk(rd_data, rows[k].idx == 3'h7 ? 8'h00 : rows[k].d);
            end
        end
        clr();
        urgent_handler_active = 1'h1;
        wr(3'h0, 8'h01, 13'h0001);
        wr(3'h1, 8'h42, 13'h0001);
        wr(3'h3, 8'h24, 13'h0001);
        repeat (2) tick;
        chk(error_state, 1'h1);
        chk(urgent_error_status_reg, 8'h00);
        weak_error_detect = 1'h1;
        urgent_handler_active = 1'h0;
        repeat (2) tick;
        chk(urgent_error_status_reg, 8'h00);
        facility_enable = 1'h1;
        repeat (2) tick;
        chk(urgent_error_status_reg, 8'h04);
        facility_enable = 1'h0;
        clr();
        weak_error_detect = 1'h0;
        repeat (2) tick;
        chk(urgent_error_status_reg, 8'h04);
        wr(3'h1, 8'h42, 13'h0000);
        urgent_handler_active = 1'h1;
        clr();
        bv_ue = 1'h1;
        pulse(bv_valid);
        chk(urgent_error_status_reg, 8'h00);
        urgent_handler_active = 1'h0;
        pulse(bv_valid);
        chk(urgent_error_status_reg, 8'h40);
        chk(auto_urgent, 1'h1);
        clr();
        wr(3'h5, 8'h81, 13'h0000);
        pulse(ptr_update);
        pr(3'h0, 8'h11, 8'h01);
        pr(3'h1, 8'h22, 8'h01);
        pr(3'h3, 8'h02, 8'h00);
        pr(3'h5, 8'h00, 8'h00);
        wr(3'h5, 8'h80, 13'h0001);
        pulse(ptr_update);
        pr(3'h4, 8'h81, 8'h02);
        pr(3'h2, 8'h80, 8'h02);
        pulse(itlb_update);
        chk(urgent_error_status_reg, 8'h20);
        clr();
        pulse(dtlb_update);
        chk(urgent_error_status_reg, 8'h20);
        clr();
        pulse(tlb_use_i);
        chk(urgent_error_status_reg, 8'h20);
        clr();
        // A lookup while the clock enable is low must leave the status frozen
        clk_en = 1'h0;
        pulse(tlb_use_d);
        chk(urgent_error_status_reg, 8'h00);
        clk_en = 1'h1;
        pulse(tlb_use_d);
        chk(urgent_error_status_reg, 8'h20);
        clr();
        pkt_data = 8'h3c;
        pulse(pkt_valid);
        chk(vector_trap, 1'h1);
        tick;
        chk(intr_busy, 1'h1);
        chk(intr_data, 8'h3c);
        pulse(pkt_valid);
        chk(vector_trap, 1'h0);
        intr_busy_wdata = 1'h1;
        pulse(intr_busy_wr);
        chk(intr_busy, 1'h1);
        intr_busy_wdata = 1'h0;
        tick;
        pulse(intr_busy_wr);
        pkt_ue = 1'h1;
        pulse(pkt_valid);
        chk(vector_trap, 1'h1);
        chk(intr_busy, 1'h0);
        chk(auto_urgent, 1'h1);
        chk(urgent_error_status_reg, 8'h80);
        pkt_ue = 1'h0;
        pulse(pkt_valid);
        chk(vector_trap, 1'h0);
        pulse(intr_busy_wr);
        pulse(pkt_valid);
        chk(vector_trap, 1'h1);
        resetn = 1'h0;
        #1;
        chk({error_state, intr_busy, urgent_error_status_reg}, 10'h000);
        tick;
        resetn = 1'h1;
        tick;
        chk({rd_valid, ptr_valid, vector_trap, instr_urgent, auto_urgent}, 5'h00);
        tick;
        chk(error_state, 1'h0);
        // A load right after the mid-run reset must be answered normally
        rd(3'h0);
        chk(rd_data, 8'h00);
        chk(urgent_error_status_reg, 8'h00);
        results();
    end
endmodule
bind arc_check arc_checker checker_i (.clock, .resetn, .urgent_handler_active,
    .weak_error_detect, .rd_en, .rd_valid, .ptr_rd, .ptr_valid, .pkt_valid, .pkt_ue, .intr_busy,
    .vector_trap, .bv_valid, .bv_ue, .ugesr_clr, .urgent_error_status_reg, .instr_urgent,
    .auto_urgent, .ecc_corrected);
`default_nettype wire

// >>> test/arc_checker.sv
// Port-level assertions for the register error checker
`timescale 1ns/10ps
`default_nettype none
module arc_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic urgent_handler_active,
    input wire logic weak_error_detect,
    input wire logic rd_en,
    input wire logic rd_valid,
    input wire logic ptr_rd,
    input wire logic ptr_valid,
    input wire logic pkt_valid,
    input wire logic pkt_ue,
    input wire logic intr_busy,
    input wire logic vector_trap,
    input wire logic bv_valid,
    input wire logic bv_ue,
    input wire logic [7:0] ugesr_clr,
    input wire logic [7:0] urgent_error_status_reg,
    input wire logic instr_urgent,
    input wire logic auto_urgent,
    input wire logic ecc_corrected
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    wire logic [7:0] st = urgent_error_status_reg;
    wire logic bv_hit = bv_valid && bv_ue && !urgent_handler_active && !weak_error_detect;
    ////////////////////////////////////////
    read_answer_a: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    ptr_answer_a: assert property (ptr_rd |=> ptr_valid)
        else $error("pointer read not answered");
    trap_cause_a: assert property (vector_trap |-> $past(pkt_valid))
        else $error("trap without packet");
    ue_busy_a: assert property (pkt_valid && pkt_ue && !intr_busy |=> !intr_busy)
        else $error("errored packet set busy");
    status_sticky_a: assert property (($past(st) & ~$past(ugesr_clr) & ~st) == 8'h00)
        else $error("status flag lost");
    bv_set_a: assert property (bv_hit |=> st[6])
        else $error("barrier error not flagged");
    bv_gate_a: assert property ($rose(st[6]) |-> $past(bv_hit))
        else $error("barrier flag outside check period");
    instr_class_a: assert property (instr_urgent |-> (st & 8'h1b) != 8'h00)
        else $error("instruction class without flag");
    auto_class_a: assert property (auto_urgent |-> (st & 8'he4) != 8'h00)
        else $error("autonomous class without flag");
    ecc_fix_a: assert property (ecc_corrected |-> rd_valid)
        else $error("correction outside read");
    cover property (vector_trap && !intr_busy);
    cover property (ecc_corrected);
    cover property (instr_urgent);
endmodule
`default_nettype wire

// >>> test/arc_pipe_model.sv
// Pipeline stand-in that issues alternate-space loads
`timescale 1ns/10ps
`default_nettype none
module arc_pipe_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [2:0] go_idx,
    input wire logic slow,
    output logic rd_en,
    output logic [2:0] rd_idx
);
    initial begin
        rd_en = 1'h0;
        rd_idx = 3'h7;
    end
    // A slow load waits, as an issue stall would
    always @(posedge clock) begin
        if (go === 1'h1) begin
            repeat (slow ? 3 : 0) @(posedge clock);
            #1;
            rd_en = 1'h1;
            rd_idx = go_idx;
            @(posedge clock);
            #1;
            rd_en = 1'h0;
            // Idle index is scrambled so no stale value is trusted
            rd_idx = ~rd_idx;
        end
    end
endmodule
`default_nettype wire
